/* nco_core_pkg.sv */
// constants, register layout and state types of the nco frequency control core
package nco_core_pkg;

    // ==========================================================
    // widths
    localparam int FREQ_W     = 48;
    localparam int SER_W      = 40;
    localparam int AMP_W      = 16;
    localparam int DAC_W      = 14;
    localparam int AXI_ADDR_W = 8;

    // ==========================================================
    // parallel register indexes (4-bit address)
    localparam logic [3:0] REG_CENTER_0   = 4'h0;
    localparam logic [3:0] REG_OFFSET_0   = 4'h6;
    localparam logic [3:0] REG_SERIAL_CFG = 4'hC;
    localparam logic [3:0] REG_CONTROL    = 4'hD;
    localparam logic [3:0] REG_TEST       = 4'hE;
    localparam logic [3:0] REG_UPDATE     = 4'hF;

    // control register (index 13) bit positions
    localparam int CTL_CENTER_EN = 4;
    localparam int CTL_ACC_EN    = 5;
    localparam int CTL_SERIAL_EN = 6;
    // serial config register (index 12) fields
    localparam int SCFG_BYTES_LSB = 0;
    localparam int SCFG_FALLING   = 3;

    // ==========================================================
    // values after reset
    localparam logic [47:0] CENTER_RST  = 48'h4000_0000_0000;
    localparam logic [47:0] OFFSET_RST  = 48'h0000_0000_0000;
    localparam logic [39:0] SERIAL_RST  = 40'h00_0000_0000;
    localparam logic [7:0]  SCFG_RST    = 8'h05;
    localparam logic [7:0]  CONTROL_RST = 8'h70;
    localparam logic [7:0]  TEST_RST    = 8'h00;
    localparam logic [13:0][7:0] REGS_RST = {CONTROL_RST, SCFG_RST, OFFSET_RST, CENTER_RST};

    // ==========================================================
    // cycle and byte counts
    localparam int UPD_STAGES = 3;
    localparam int PIN_STAGES = 4;
    localparam int INC_STAGES = 5;
    localparam logic [1:0] XFER_SCLKS = 2'h2;
    localparam logic [2:0] SER_MAX_BYTES = 3'h5;

    // sine approximation coefficients, q0.16
    localparam logic [16:0] SINE_C0 = 17'h0_C666;
    localparam logic [33:0] SINE_C1 = 34'h0_0000_399A;

    // ==========================================================
    // axi4-lite map
    localparam logic [7:0] AXI_CTRL   = 8'h00;
    localparam logic [7:0] AXI_STATUS = 8'h04;
    localparam logic [7:0] AXI_INC_LO = 8'h08;
    localparam logic [7:0] AXI_INC_HI = 8'h0C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // pin groups, serial states and core state
    typedef struct packed {
        logic       wr;
        logic       we_n;
        logic [3:0] addr;
        logic [7:0] data;
    } par_port_t;

    typedef struct packed {
        logic sclk;
        logic serial_data;
        logic serial_sync;
    } ser_pins_t;

    typedef struct packed {
        logic       update_n;
        logic       offset_freq_enable;
        logic [1:0] phase_select;
    } mod_pins_t;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'h1,
        SER_SHIFT = 3'h2,
        SER_XFER  = 3'h4
    } ser_state_t;

    typedef struct packed {
        par_port_t                        par_s1;
        par_port_t                        par_s2;
        logic                             wr_d;
        ser_pins_t                        ser_s1;
        ser_pins_t                        ser_s2;
        logic                             sclk_d;
        mod_pins_t                        mod_s1;
        mod_pins_t                        mod_s2;
        logic [UPD_STAGES-1:0]            upd_pipe;
        logic [PIN_STAGES-1:0]            ofe_pipe;
        logic [PIN_STAGES-1:0][1:0]       ph_pipe;
        logic [13:0][7:0]                 master;
        logic [13:0][7:0]                 slave;
        logic [7:0]                       test_reg;
        ser_state_t                       ser_state;
        logic [5:0]                       ser_cnt;
        logic [1:0]                       xfer_cnt;
        logic [SER_W-1:0]                 ser_shift;
        logic [SER_W-1:0]                 ser_hold;
        logic [SER_W-1:0]                 ser_word;
        logic [INC_STAGES-1:0][FREQ_W-1:0] inc_pipe;
        logic [FREQ_W-1:0]                acc;
        logic [AMP_W-1:0]                 amp;
        logic [DAC_W-1:0]                 sample;
        logic [AXI_ADDR_W-1:0]            aw_addr;
        logic                             aw_full;
        logic [31:0]                      w_data;
        logic [3:0]                       w_strb;
        logic                             w_full;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        logic                             soft_update;
    } core_state_t;

endpackage

/* nco_frequency_control_core.sv */
// nco core: phase accumulator, sine lookup, parallel and serial tuning, axi4-lite status
// Notes on behaviour
// - increment is center plus offset plus serial word, kept to 48 bits.
// - center and serial terms zeroed by register bits, offset by pin.
// - serial word of 8 to 40 bits sits in the top bits, zeros below.
// - accumulate every clock; top 24 phase bits feed one-cycle sine lookup.
// - 16-bit amplitude is rounded to the 14-bit converter sample.
// - bit 47 weighs 180 degrees; phase wraps to zero after full scale.
// - parallel port is write-only: 8 data, 4 address, strobe, enable.
// - writes land in master registers; update copies all to slaves together.
// - output changes 11 clocks after write with update held, else 14.
// - writes accepted pipelined up to half clock rate; strobe is asynchronous.
// - offset term passes while enable pin high; change shows 14 clocks later.
// - output phase shifted by 0, 90, 180 or 270 degrees.
// - phase select 00 none, 01 90, 10 180, 11 270 degrees.
// - phase select, offset enable and update pins pass synchronisers first.
// - writing any value to register 15 acts as an update.
// - finished serial word goes to holding register, then to ser_word.
// - serial load takes 8 clocks per byte plus three more.
// - new serial frequency reaches the output within 12 clocks.
// - center and offset words are written only by the parallel port.
// - output reflects reset within 11 clocks; writes one edge after release.
// - reset gives center quarter clock rate, offset disabled, serial enabled.
// - reset zeroes accumulator feedback, honoured only while update is low.
// - data latched on strobe rising edge only while write enable is low.
`timescale 1ns/1ps
module nco_frequency_control_core (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire nco_core_pkg::par_port_t   par_port,
    input  wire nco_core_pkg::ser_pins_t   ser_pins,
    input  wire nco_core_pkg::mod_pins_t   mod_pins,
    output logic [nco_core_pkg::DAC_W-1:0] dac_sample,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    // ==========================================================
    // sine approximation
    // corrected parabola, about 0.1 % error:
    // far cheaper than a 16M-entry table
    function automatic logic [15:0] sine_amp(input logic [23:0] ph);
        logic [15:0] x;
        logic [31:0] prod;
        logic [16:0] p;
        logic [33:0] t;
        logic [16:0] k;
        logic [33:0] y2;
        logic [16:0] y;
        logic [15:0] mag;
        x    = ph[22:7];
        prod = {16'h0000, x} * (32'h0001_0000 - {16'h0000, x});
        p    = prod[30:14];
        t    = {17'h0_0000, p} * nco_core_pkg::SINE_C1;
        k    = nco_core_pkg::SINE_C0 + t[32:16];
        y2   = {17'h0_0000, p} * {17'h0_0000, k};
        y    = y2[32:16];
        mag  = (y[16:1] > 16'h7FFF) ? 16'h7FFF : y[16:1];
        // bit 23 of the lookup phase is accumulator bit 47 after the phase offset: second half cycle
        return ph[23] ? (16'h0000 - mag) : mag;
    endfunction

    // round half up, saturating at the positive end
    function automatic logic [13:0] round14(input logic [15:0] a);
        if (a[15:2] == 14'h1FFF && a[1]) begin
            return 14'h1FFF;
        end
        return a[15:2] + {13'h0000, a[1]};
    endfunction

    // ==========================================================
    // state and combinational terms
    nco_core_pkg::core_state_t cur;
    nco_core_pkg::core_state_t next_cur;

    logic        wr_take;
    logic        reg15_wr;
    logic        upd_active;
    logic        upd_in;
    logic [2:0]  ser_bytes;
    logic [5:0]  ser_bits;
    logic        sclk_edge;
    logic [47:0] center_term;
    logic [47:0] offset_term;
    logic [47:0] serial_term;
    logic [47:0] inc_sum;
    logic [23:0] ph_idx;
    logic [7:0]  ctl;
    logic [7:0]  scfg;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic [7:0]  aw_word;
    logic [7:0]  ar_word;

    assign ctl  = cur.slave[nco_core_pkg::REG_CONTROL];
    assign scfg = cur.slave[nco_core_pkg::REG_SERIAL_CFG];

    // ==========================================================
    // parallel port strobe detection
    // strobe edge gating
    assign wr_take  = cur.par_s2.wr & ~cur.wr_d & ~cur.par_s2.we_n;
    assign reg15_wr = wr_take & (cur.par_s2.addr == nco_core_pkg::REG_UPDATE);
    assign upd_in   = ~cur.mod_s2.update_n | reg15_wr | cur.soft_update;
    assign upd_active = cur.upd_pipe[nco_core_pkg::UPD_STAGES-1];

    // ==========================================================
    // serial timing terms
    // out-of-range byte counts fall back to the full 40-bit word
    assign ser_bytes = (scfg[2:0] == 3'h0 || scfg[2:0] > nco_core_pkg::SER_MAX_BYTES)
                       ? nco_core_pkg::SER_MAX_BYTES : scfg[2:0];
    assign ser_bits  = {ser_bytes, 3'h0};
    assign sclk_edge = scfg[nco_core_pkg::SCFG_FALLING]
                       ? (~cur.ser_s2.sclk & cur.sclk_d)
                       : (cur.ser_s2.sclk & ~cur.sclk_d);

    // ==========================================================
    // frequency sum
    // per-term zeroing
    assign center_term = ctl[nco_core_pkg::CTL_CENTER_EN] ? cur.slave[5:0] : 48'h0000_0000_0000;
    assign offset_term = cur.ofe_pipe[nco_core_pkg::PIN_STAGES-1] ? cur.slave[11:6]
                         : 48'h0000_0000_0000;
    assign serial_term = ctl[nco_core_pkg::CTL_SERIAL_EN] ? {cur.ser_word, 8'h00}
                         : 48'h0000_0000_0000;
    assign inc_sum = center_term + offset_term + serial_term;

    assign ph_idx = cur.acc[47:24] + {cur.ph_pipe[nco_core_pkg::PIN_STAGES-1], 22'h00_0000};

    // ==========================================================
    // axi4-lite handshakes
    assign s_axi_awready = ~cur.aw_full;
    assign s_axi_wready  = ~cur.w_full;
    assign s_axi_arready = ~cur.rvalid;
    assign aw_hs   = s_axi_awvalid & ~cur.aw_full;
    assign w_hs    = s_axi_wvalid & ~cur.w_full;
    assign ar_hs   = s_axi_arvalid & ~cur.rvalid;
    assign aw_word = {cur.aw_addr[7:2], 2'h0};
    assign ar_word = {s_axi_araddr[7:2], 2'h0};

    // ==========================================================
    // next state
    always_comb begin
        next_cur = cur;

        next_cur.par_s1 = par_port;
        next_cur.par_s2 = cur.par_s1;
        next_cur.wr_d   = cur.par_s2.wr;
        next_cur.ser_s1 = ser_pins;
        next_cur.ser_s2 = cur.ser_s1;
        next_cur.sclk_d = cur.ser_s2.sclk;
        next_cur.mod_s1 = mod_pins;
        next_cur.mod_s2 = cur.mod_s1;

        next_cur.upd_pipe = {cur.upd_pipe[nco_core_pkg::UPD_STAGES-2:0], upd_in};
        next_cur.ofe_pipe = {cur.ofe_pipe[nco_core_pkg::PIN_STAGES-2:0],
                             cur.mod_s2.offset_freq_enable};
        next_cur.ph_pipe = {cur.ph_pipe[nco_core_pkg::PIN_STAGES-2:0],
                            cur.mod_s2.phase_select};

        // only the parallel port loads center and offset
        if (wr_take && cur.par_s2.addr < nco_core_pkg::REG_TEST) begin
            next_cur.master[cur.par_s2.addr] = cur.par_s2.data;
        end
        if (wr_take && cur.par_s2.addr == nco_core_pkg::REG_TEST) begin
            next_cur.test_reg = cur.par_s2.data;
        end
        if (upd_active) begin
            next_cur.slave = next_cur.master;
        end

        if (sclk_edge) begin
            if (cur.ser_s2.serial_sync) begin
                next_cur.ser_state = nco_core_pkg::SER_SHIFT;
                next_cur.ser_cnt   = 6'h00;
                next_cur.ser_shift = 40'h00_0000_0000;
            end else begin
                unique case (cur.ser_state)
                    nco_core_pkg::SER_IDLE: begin
                        next_cur.ser_state = nco_core_pkg::SER_IDLE;
                    end
                    nco_core_pkg::SER_SHIFT: begin
                        next_cur.ser_shift = {cur.ser_shift[38:0], cur.ser_s2.serial_data};
                        next_cur.ser_cnt   = cur.ser_cnt + 6'h01;
                        if (cur.ser_cnt + 6'h01 == ser_bits) begin
                            next_cur.ser_hold  = next_cur.ser_shift << (6'd40 - ser_bits);
                            next_cur.ser_state = nco_core_pkg::SER_XFER;
                            next_cur.xfer_cnt  = nco_core_pkg::XFER_SCLKS;
                        end
                    end
                    nco_core_pkg::SER_XFER: begin
                        next_cur.xfer_cnt = cur.xfer_cnt - 2'h1;
                        if (cur.xfer_cnt == 2'h1) begin
                            next_cur.ser_word  = cur.ser_hold;
                            next_cur.ser_state = nco_core_pkg::SER_IDLE;
                        end
                    end
                    default: begin
                        next_cur.ser_state = nco_core_pkg::SER_IDLE;
                    end
                endcase
            end
        end

        next_cur.inc_pipe = {cur.inc_pipe[nco_core_pkg::INC_STAGES-2:0], inc_sum};
        next_cur.acc = ctl[nco_core_pkg::CTL_ACC_EN]
                       ? cur.acc + cur.inc_pipe[nco_core_pkg::INC_STAGES-1]
                       : 48'h0000_0000_0000;
        next_cur.amp = sine_amp(ph_idx);
        next_cur.sample = round14(cur.amp);

        // axi write: address and data taken in either order
        if (aw_hs) begin
            next_cur.aw_addr = s_axi_awaddr;
            next_cur.aw_full = 1'b1;
        end
        if (w_hs) begin
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
            next_cur.w_full = 1'b1;
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        if (cur.aw_full && cur.w_full && !cur.bvalid) begin
            next_cur.bvalid  = 1'b1;
            next_cur.aw_full = 1'b0;
            next_cur.w_full  = 1'b0;
            if (aw_word == nco_core_pkg::AXI_CTRL) begin
                next_cur.bresp = nco_core_pkg::RESP_OKAY;
                if (cur.w_strb[0]) begin
                    next_cur.soft_update = cur.w_data[0];
                end
            end else begin
                next_cur.bresp = nco_core_pkg::RESP_SLVERR;
            end
        end

        // axi read
        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (ar_hs) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp  = nco_core_pkg::RESP_OKAY;
            unique case (ar_word)
                nco_core_pkg::AXI_CTRL:   next_cur.rdata = {31'h0000_0000, cur.soft_update};
                nco_core_pkg::AXI_STATUS: next_cur.rdata = {13'h0000,
                    cur.ser_state != nco_core_pkg::SER_IDLE, upd_active,
                    cur.ofe_pipe[nco_core_pkg::PIN_STAGES-1],
                    cur.ph_pipe[nco_core_pkg::PIN_STAGES-1], cur.sample};
                nco_core_pkg::AXI_INC_LO:
                    next_cur.rdata = cur.inc_pipe[nco_core_pkg::INC_STAGES-1][31:0];
                nco_core_pkg::AXI_INC_HI:
                    next_cur.rdata = {16'h0000, cur.inc_pipe[nco_core_pkg::INC_STAGES-1][47:32]};
                default: begin
                    next_cur.rdata = 32'h0000_0000;
                    next_cur.rresp = nco_core_pkg::RESP_SLVERR;
                end
            endcase
        end

        // reset only while update is low
        if (!aresetn && !cur.mod_s2.update_n) begin
            next_cur.upd_pipe  = '0;
            next_cur.ofe_pipe  = '0;
            next_cur.ph_pipe   = '0;
            next_cur.master    = nco_core_pkg::REGS_RST;
            next_cur.slave     = nco_core_pkg::REGS_RST;
            next_cur.test_reg  = nco_core_pkg::TEST_RST;
            next_cur.ser_state = nco_core_pkg::SER_IDLE;
            next_cur.ser_cnt   = 6'h00;
            next_cur.xfer_cnt  = 2'h0;
            next_cur.ser_shift = nco_core_pkg::SERIAL_RST;
            next_cur.ser_hold  = nco_core_pkg::SERIAL_RST;
            next_cur.ser_word  = nco_core_pkg::SERIAL_RST;
            next_cur.inc_pipe  = '0;
            next_cur.acc       = 48'h0000_0000_0000;
            next_cur.amp       = 16'h0000;
            next_cur.sample    = 14'h0000;
        end
        // the bus side resets unconditionally so software never hangs
        if (!aresetn) begin
            next_cur.aw_addr     = 8'h00;
            next_cur.aw_full     = 1'b0;
            next_cur.w_data      = 32'h0000_0000;
            next_cur.w_strb      = 4'h0;
            next_cur.w_full      = 1'b0;
            next_cur.bvalid      = 1'b0;
            next_cur.bresp       = nco_core_pkg::RESP_OKAY;
            next_cur.rvalid      = 1'b0;
            next_cur.rdata       = 32'h0000_0000;
            next_cur.rresp       = nco_core_pkg::RESP_OKAY;
            next_cur.soft_update = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        cur <= next_cur;
    end

    // ==========================================================
    // outputs
    assign dac_sample   = cur.sample;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp  = cur.bresp;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata  = cur.rdata;
    assign s_axi_rresp  = cur.rresp;

endmodule

/* nco_core_properties.sv */
// nco core checker
`timescale 1ns/1ps
module nco_core_properties (
    input logic                    aclk,
    input logic                    aresetn,
    input nco_core_pkg::mod_pins_t mod_pins,
    input logic [13:0]             dac_sample,
    input logic [7:0]              s_axi_awaddr,
    input logic                    s_axi_awvalid,
    input logic                    s_axi_awready,
    input logic                    s_axi_wvalid,
    input logic                    s_axi_wready,
    input logic [1:0]              s_axi_bresp,
    input logic                    s_axi_bvalid,
    input logic                    s_axi_bready,
    input logic [7:0]              s_axi_araddr,
    input logic                    s_axi_arvalid,
    input logic                    s_axi_arready,
    input logic [31:0]             s_axi_rdata,
    input logic [1:0]              s_axi_rresp,
    input logic                    s_axi_rvalid,
    input logic                    s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // properties
    // core reset only takes hold once update has crossed its synchroniser
    rst_clear_a: assert property (disable iff (1'b0)
        (!aresetn && !mod_pins.update_n) [*4] |=> dac_sample == '0) else $error("sample kept");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken early");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready && !s_axi_wvalid |=> !s_axi_awready)
        else $error("second address taken");
    wr_error_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr != 8'h00 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("write to status accepted");
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0F
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == '0) else $error("unmapped read answered");
endmodule
bind nco_frequency_control_core nco_core_properties chk (.*);

/* nco_host_model.sv */
// host model for the parallel and serial pins
`timescale 1ns/1ps
module nco_host_model (
    input  wire logic               aclk,
    output nco_core_pkg::par_port_t par_port,
    output nco_core_pkg::ser_pins_t ser_pins
);
    initial begin
        par_port = 14'h1000;
        ser_pins = '0;
    end
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d, input logic en_n);
        par_port.addr <= a;
        par_port.data <= d;
        par_port.we_n <= en_n;
        repeat (3) @(posedge aclk);
        par_port.wr <= 1'b1;
        repeat (3) @(posedge aclk);
        par_port.wr <= 1'b0;
        repeat (3) @(posedge aclk);
        par_port.we_n <= 1'b1;
        par_port.data <= ~d;
        @(posedge aclk);
    endtask
    task automatic load_serial(input logic [39:0] w, input int n);
        for (int i = -1; i < 8 * n + 2; i++) begin
            ser_pins.serial_sync <= (i < 0);
            ser_pins.serial_data <= (i >= 0 && i < 8 * n) ? w[39 - i] : ~ser_pins.serial_data;
            repeat (4) @(posedge aclk);
            ser_pins.sclk <= 1'b1;
            repeat (4) @(posedge aclk);
            ser_pins.sclk <= 1'b0;
        end
    endtask
endmodule

/* nco_frequency_control_core_test.sv */
// self-checking bench for the nco core
`timescale 1ns/1ps
module nco_frequency_control_core_test;
    logic                    aclk = 1'b0;
    logic                    aresetn = 1'b0;
    nco_core_pkg::par_port_t par_port;
    nco_core_pkg::ser_pins_t ser_pins;
    nco_core_pkg::mod_pins_t mod_pins = '0;
    logic [13:0]             dac_sample;
    logic [7:0]              s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]             s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]              s_axi_wstrb = 4'hf;
    logic                    s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                    s_axi_arvalid = 0, s_axi_rready = 0;
    logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    logic [65:0]             exp_q[$];
    logic [65:0]             e;
    logic [63:0]             seed = 64'h0000_0000_0000_e824;
    logic [47:0]             c, o;
    int                      miscompares = 0, cmp_count = 0;
    nco_frequency_control_core dut (.*);
    nco_host_model host (.*);
    always #4 aclk = ~aclk;
    function automatic logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction
    task automatic stop_test();
        $display("compares %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // one transfer; {mask, resp, data} noted first
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [1:0] r);
        bit         done = 0;
        exp_q.push_back({m, r, d});
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (int n = 0; n < 64 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (!done) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic chk_inc(input logic [47:0] v);
        axi(0, 8'h08, v[31:0], '1, 2'h0);
        axi(0, 8'h0C, {16'h0000, v[47:32]}, 32'h0000_ffff, 2'h0);
    endtask
    task automatic set_word(input logic [3:0] base, input logic [47:0] v);
        for (int i = 0; i < 6; i++) host.write_reg(base + 4'(i), v[8 * i +: 8], 1'b0);
    endtask
    // masked compare of each response
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            e = exp_q.pop_front();
            cmp_count++;
            if ((s_axi_bvalid ? s_axi_bresp : s_axi_rresp) !== e[33:32]
                || ((s_axi_rdata ^ e[31:0]) & e[65:34]) !== '0) begin
                miscompares++;
                $display("unexpected response at %0t: data %h", $time, s_axi_rdata);
            end
        end
    end
    initial begin
        idle(20);
        aresetn <= 1'b1;
        mod_pins.update_n <= 1'b1;
        host.write_reg(nco_core_pkg::REG_TEST, 8'h00, 1'b0);
        chk_inc(nco_core_pkg::CENTER_RST);
        axi(1, 8'h08, '1, '0, 2'h2);
        axi(0, 8'h10, '0, '1, 2'h2);
        axi(1, 8'h00, '0, '0, 2'h0);
        c = 48'(rnd());
        o = 48'(rnd());
        set_word(nco_core_pkg::REG_CENTER_0, c);
        host.write_reg(nco_core_pkg::REG_CENTER_0, ~c[7:0], 1'b1);
        set_word(nco_core_pkg::REG_OFFSET_0, o);
        chk_inc(nco_core_pkg::CENTER_RST);
        host.write_reg(nco_core_pkg::REG_UPDATE, 8'(rnd()), 1'b0);
        idle(20);
        chk_inc(c);
        mod_pins.offset_freq_enable <= 1'b1;
        idle(20);
        chk_inc(c + o);
        axi(0, 8'h04, 32'h0001_0000, 32'h0001_0000, 2'h0);
        mod_pins.update_n <= 1'b0;
        host.write_reg(nco_core_pkg::REG_CONTROL, 8'h60, 1'b0);
        idle(20);
        chk_inc(o);
        host.write_reg(nco_core_pkg::REG_CONTROL, 8'h70, 1'b0);
        mod_pins.update_n <= 1'b1;
        mod_pins.offset_freq_enable <= 1'b0;
        idle(20);
        chk_inc(c);
        for (int n = 1; n < 6; n++) begin
            host.write_reg(nco_core_pkg::REG_SERIAL_CFG, 8'(n), 1'b0);
            host.write_reg(nco_core_pkg::REG_UPDATE, 8'h00, 1'b0);
            o = 48'(rnd());
            host.load_serial(o[39:0], n);
            idle(20);
            chk_inc(c + ({o[39:0], 8'h00} & ~(48'hffff_ffff_ffff >> (8 * n))));
        end
        for (int p = 0; p < 4; p++) begin
            mod_pins.phase_select <= 2'(p);
            idle(12);
            axi(0, 8'h04, 32'(p) << 14, 32'h0000_c000, 2'h0);
        end
        aresetn <= 1'b0;
        mod_pins.update_n <= 1'b0;
        idle(6);
        aresetn <= 1'b1;
        mod_pins.update_n <= 1'b1;
        host.write_reg(nco_core_pkg::REG_TEST, 8'h30, 1'b0);
        chk_inc(nco_core_pkg::CENTER_RST);
        stop_test();
    end
endmodule
